/* logic/cs_pkg.sv */
package cs_pkg;

  // ==========================================================
  // widths
  // ==========================================================
  localparam int          PC_W        = 13;          // program counter width
  localparam int          PCL_W       = 8;           // low byte of the counter
  localparam int          LATCH_W     = 5;           // implemented upper latch bits
  localparam int          TRIM_W      = 6;           // oscillator trim field width
  localparam int          OPER_W      = 11;          // call or jump address operand
  localparam int          REG_W       = 8;           // register data width
  localparam int          IDX_W       = 8;           // register index width

  // ==========================================================
  // register indices, byte address is four times the index
  // ==========================================================
  localparam logic [7:0]  IDX_PC_LOW  = 8'h02;       // program counter low byte
  localparam logic [7:0]  IDX_LATCH   = 8'h0a;       // program counter upper latch
  localparam logic [7:0]  IDX_FLAGS   = 8'h0c;       // sticky interrupt flags
  localparam logic [7:0]  IDX_MASK    = 8'h8c;       // interrupt enable mask
  localparam logic [7:0]  IDX_RCAUSE  = 8'h8e;       // reset_cause
  localparam logic [7:0]  IDX_TRIM    = 8'h90;       // oscillator_trim

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int          FLG_EE      = 7;           // write-complete flag
  localparam int          FLG_ADC     = 6;           // converter_done_flag
  localparam int          FLG_CMP     = 3;           // comparator_change_flag
  localparam int          FLG_TMR     = 0;           // timer_overflow_flag
  localparam logic [7:0]  FLG_IMPL    = 8'hc9;       // implemented flag bits
  localparam int          RC_POR      = 1;           // power_on_flag
  localparam int          RC_BOD      = 0;           // brownout_flag
  localparam int          TRIM_LSB    = 2;           // trim_field sits in bits 7..2
  localparam int          JMP_HI      = 4;           // latch bits used by call/jump
  localparam int          JMP_LO      = 3;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [5:0]  TRIM_RST    = 6'h20;       // centre frequency code
  localparam logic        POR_RST     = 1'b0;        // power-on seen
  localparam logic        BOD_RST     = 1'b1;        // no brown-out assumed
  localparam logic [12:0] PC_RST      = 13'h0000;    // first program location
  localparam logic [12:0] PC_ONE      = 13'h0001;    // sequential step

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic ee_done;                                   // data eeprom write finished
    logic adc_done;                                  // conversion finished
    logic tmr_ovf;                                   // timer overflow pulse
    logic por;                                       // power-on reset event
    logic brownout_flag;                                       // brown-out event
    logic other_rst;                                 // watchdog or pin reset
  } cs_evt_t;

  typedef struct packed {
    logic              step;                         // advance by one
    logic              jump;                         // call or absolute jump
    logic [OPER_W-1:0] oper;                         // jump address operand
  } cs_pc_cmd_t;

  typedef struct packed {
    logic [PC_W-1:0]    pc;                          // program counter
    logic [LATCH_W-1:0] latch;                       // upper latch
    logic [TRIM_W-1:0]  trim;                        // trim field
    logic               por_flag;                    // low after power-on
    logic               bod_flag;                    // low after brown-out
    logic [REG_W-1:0]   flags;                       // sticky flags
    logic [REG_W-1:0]   mask;                        // interrupt mask
    logic               ack;                         // bus acknowledge
    logic [REG_W-1:0]   rdat;                        // read data
  } cs_state_t;

endpackage : cs_pkg

/* logic/cs_sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module cs_sync3 (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      change_out
);

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic s1;                                        // first stage, read by s2 only
    logic s2;                                        // second stage
    logic s3;                                        // third stage
    logic lvl;                                       // accepted level
    logic chg;                                       // one-cycle change pulse
  } cs_sync_t;

  cs_sync_t st_q;
  cs_sync_t st_d;

  // ==========================================================
  // next state: level accepted once stages two and three agree
  // ==========================================================
  always_comb begin
    st_d     = st_q;
    st_d.s1  = async_in;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    st_d.chg = 1'b0;
    if ((st_q.s2 == st_q.s3) && (st_q.s3 != st_q.lvl)) begin
      st_d.lvl = st_q.s3;
      st_d.chg = 1'b1;
    end
  end

  // registers, constants only under reset
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out  = st_q.lvl;
  assign change_out = st_q.chg;

endmodule : cs_sync3

`default_nettype wire

/* logic/cs_core.sv */
`timescale 1ns/1ps
`default_nettype none

module cs_core
  import cs_pkg::*;
#(
  parameter int ADR_W = 10                           // wishbone byte address width
) (
  input  wire logic              clk_sys_in,
  input  wire logic              reset_n_in,
  // wishbone classic slave
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [ADR_W-1:0]  wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic      [31:0]       wb_dat_out,
  output logic                   wb_ack_out,
  // event sources
  input  wire cs_evt_t           evt_in,
  input  wire logic              cmp_level_in,
  // core program counter control
  input  wire cs_pc_cmd_t        pc_cmd_in,
  output logic      [PC_W-1:0]   pc_out,
  // oscillator trim and interrupt
  output logic      [TRIM_W-1:0] trim_out,
  output logic                   irq_out
);

  // ==========================================================
  // helpers
  // ==========================================================
  // sticky bit: set wins, a written zero clears
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic wr, input logic val);
    sticky = set | (cur & ~(wr & ~val));
  endfunction : sticky

  // ==========================================================
  // signals
  // ==========================================================
  cs_state_t             st_q;                       // registered state
  cs_state_t             st_d;                       // next state
  logic                  cmp_chg;                    // comparator change pulse
  logic                  req;                        // bus request present
  logic                  wr_go;                      // write commit edge
  logic [IDX_W-1:0]      idx;                        // register index
  logic [REG_W-1:0]      wdat;                       // written byte
  logic [REG_W-1:0]      rd_mux;                     // read value
  logic [REG_W-1:0]      set_vec;                    // flag set events
  logic                  any_rst;                    // any reset event
  logic                  wr_pcl;                     // low byte write
  logic                  wr_flags;                   // flag register write
  logic                  wr_rc;                      // reset_cause write

  // ==========================================================
  // comparator synchroniser
  // ==========================================================
  // only the change pulse is used, the level itself is not needed
  cs_sync3 cs_sync3_inst (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .async_in   (cmp_level_in),
    .level_out  (),
    .change_out (cmp_chg)
  );

  // ==========================================================
  // bus decode
  // ==========================================================
  always_comb begin
    req      = wb_cyc_in & wb_stb_in;
    wr_go    = req & wb_we_in & st_q.ack & wb_sel_in[0];
    idx      = wb_adr_in[ADR_W-1:2];
    wdat     = wb_dat_in[REG_W-1:0];
    wr_pcl   = wr_go & (idx == IDX_PC_LOW);
    wr_flags = wr_go & (idx == IDX_FLAGS);
    wr_rc    = wr_go & (idx == IDX_RCAUSE);
    any_rst  = evt_in.por | evt_in.brownout_flag | evt_in.other_rst;
  end

  // read multiplexer, unmapped reads give zero
  always_comb begin
    rd_mux = '0;
    case (idx)
      IDX_PC_LOW: begin
        rd_mux = st_q.pc[PCL_W-1:0];
      end
      IDX_LATCH: begin
        rd_mux[LATCH_W-1:0] = st_q.latch;
      end
      IDX_FLAGS: begin
        rd_mux = st_q.flags & FLG_IMPL;
      end
      IDX_MASK: begin
        rd_mux = st_q.mask & FLG_IMPL;
      end
      IDX_RCAUSE: begin
        rd_mux[RC_POR] = st_q.por_flag;
        rd_mux[RC_BOD] = st_q.bod_flag;
      end
      IDX_TRIM: begin
        rd_mux[REG_W-1:TRIM_LSB] = st_q.trim;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // ==========================================================
  // flag events
  // ==========================================================
  always_comb begin
    set_vec          = '0;
    set_vec[FLG_EE]  = evt_in.ee_done;
    set_vec[FLG_ADC] = evt_in.adc_done;
    set_vec[FLG_CMP] = cmp_chg;
    set_vec[FLG_TMR] = evt_in.tmr_ovf;
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    st_d = st_q;
    // acknowledge one cycle after the request, drop after
    st_d.ack  = req & ~st_q.ack;
    if (req & ~st_q.ack) begin
      st_d.rdat = rd_mux;
    end
    // sticky flags, hardware never clears them
    for (int i = 0; i < REG_W; i++) begin
      st_d.flags[i] = FLG_IMPL[i] &
                      sticky(st_q.flags[i], set_vec[i], wr_flags, wdat[i]);
    end
    // reset_cause bits latch the event low, software writes one back
    st_d.por_flag = ~sticky(~st_q.por_flag, evt_in.por, wr_rc, ~wdat[RC_POR]);
    st_d.bod_flag = ~sticky(~st_q.bod_flag, evt_in.brownout_flag, wr_rc, ~wdat[RC_BOD]);
    // plain registers, written on the commit edge
    if (wr_go && idx == IDX_MASK) begin
      st_d.mask = wdat & FLG_IMPL;
    end
    // upper latch, five implemented bits
    if (wr_go && idx == IDX_LATCH) begin
      st_d.latch = wdat[LATCH_W-1:0];
    end
    // trim field, the two low bits are unimplemented
    if (wr_go && idx == IDX_TRIM) begin
      st_d.trim = wdat[REG_W-1:TRIM_LSB];
    end
    // program counter, reset events first
    if (any_rst) begin
      st_d.pc = PC_RST;
    end else if (wr_pcl) begin
      st_d.pc = {st_q.latch, wdat};
    end else if (pc_cmd_in.jump) begin
      st_d.pc = {st_q.latch[JMP_HI:JMP_LO], pc_cmd_in.oper};
    end else if (pc_cmd_in.step) begin
      st_d.pc = st_q.pc + PC_ONE;
    end
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      st_q          <= '0;
      st_q.pc       <= PC_RST;
      st_q.trim     <= TRIM_RST;
      st_q.por_flag <= POR_RST;
      st_q.bod_flag <= BOD_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign wb_ack_out = st_q.ack;
  assign wb_dat_out = {{(32-REG_W){1'b0}}, st_q.rdat};
  assign pc_out     = st_q.pc;
  assign trim_out   = st_q.trim;
  assign irq_out    = |(st_q.flags & st_q.mask);

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  AST_EE_SET: assert property (evt_in.ee_done |=> st_q.flags[FLG_EE])
    else $error("write-complete flag not set");
  AST_ADC_SET: assert property (evt_in.adc_done |=> st_q.flags[FLG_ADC])
    else $error("converter flag not set");
  AST_CMP_SET: assert property ($rose(cmp_chg) |=> st_q.flags[FLG_CMP])
    else $error("comparator flag not set");
  AST_TMR_HOLD: assert property ((st_q.flags[FLG_TMR] && !wr_flags)
                                 |=> st_q.flags[FLG_TMR])
    else $error("timer flag dropped without write");
  AST_POR_LOW: assert property (evt_in.por |=> !st_q.por_flag)
    else $error("power-on flag not driven low");
  AST_BOD_HOLD: assert property ((st_q.bod_flag && !evt_in.brownout_flag
                                  && !(wr_rc && !wdat[RC_BOD]))
                                 |=> st_q.bod_flag)
    else $error("brownout flag lost without event");
  AST_RC_UPPER: assert property ((st_q.ack && idx == IDX_RCAUSE)
                                 |-> wb_dat_out[REG_W-1:2] == '0)
    else $error("reset_cause upper bits not zero");
  AST_PC_RESET: assert property (any_rst |=> pc_out == PC_RST)
    else $error("counter not cleared by reset event");
  AST_PCL_LOAD: assert property ((wr_pcl && !any_rst)
                                 |=> pc_out == {$past(st_q.latch), $past(wdat)})
    else $error("low byte write load wrong");
  AST_JUMP: assert property ((pc_cmd_in.jump && !any_rst && !wr_pcl)
                             |=> pc_out[PC_W-1:OPER_W] == $past(st_q.latch[JMP_HI:JMP_LO])
                                 && pc_out[OPER_W-1:0] == $past(pc_cmd_in.oper))
    else $error("call or jump load wrong");
  AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");

  // ==========================================================
  // checks: sticky flags and interrupt
  // ==========================================================
  // timer overflow sets its flag
  AST_TMR_SET: assert property (evt_in.tmr_ovf |=> st_q.flags[FLG_TMR])
    else $error("timer flag not set");
  // with no event, a write keeps only the bits written as one
  AST_FLAG_WR: assert property ((wr_flags && set_vec == '0)
                                |=> st_q.flags == ($past(st_q.flags) & $past(wdat)))
    else $error("flag write result wrong");
  // with no event and no write the flags stand still
  AST_FLAG_HOLD: assert property ((!wr_flags && set_vec == '0)
                                  |=> $stable(st_q.flags))
    else $error("flag changed without cause");
  // unimplemented flag bits read zero
  AST_FLAG_UNUSED: assert property ((st_q.ack && idx == IDX_FLAGS)
                                    |-> (wb_dat_out[REG_W-1:0] & ~FLG_IMPL) == '0)
    else $error("unimplemented flag bit read as one");
  // an enabled, set comparator flag raises the interrupt
  AST_IRQ_ON: assert property ((st_q.flags[FLG_CMP] && st_q.mask[FLG_CMP]) |-> irq_out)
    else $error("interrupt not raised");
  // an empty mask keeps the interrupt low
  AST_IRQ_OFF: assert property ((st_q.mask == '0) |-> !irq_out)
    else $error("interrupt raised with empty mask");

  // ==========================================================
  // checks: reset cause
  // ==========================================================
  // brown-out drives its flag low
  AST_BOD_LOW: assert property (evt_in.brownout_flag |=> !st_q.bod_flag)
    else $error("brownout flag not driven low");
  // software writes the brown-out flag back to one
  AST_BOD_WR: assert property ((wr_rc && wdat[RC_BOD] && !evt_in.brownout_flag)
                               |=> st_q.bod_flag)
    else $error("brownout flag not restored");
  // power-on flag holds with no event and no written zero
  AST_POR_HOLD: assert property ((st_q.por_flag && !evt_in.por
                                  && !(wr_rc && !wdat[RC_POR]))
                                 |=> st_q.por_flag)
    else $error("power-on flag lost without event");
  // a read shows both cause bits as they stood when taken
  AST_RC_READ: assert property ((st_q.ack && idx == IDX_RCAUSE)
                                |-> wb_dat_out[RC_POR] == $past(st_q.por_flag)
                                    && wb_dat_out[RC_BOD] == $past(st_q.bod_flag))
    else $error("reset_cause read wrong");

  // ==========================================================
  // checks: oscillator trim
  // ==========================================================
  // a trim write lands in the six upper bits
  AST_TRIM_WR: assert property ((wr_go && idx == IDX_TRIM)
                                |=> trim_out == $past(wdat[REG_W-1:TRIM_LSB]))
    else $error("trim write lost");
  // the trim code moves only on a write
  AST_TRIM_HOLD: assert property (!(wr_go && idx == IDX_TRIM)
                                  |=> $stable(trim_out))
    else $error("trim code changed without write");
  // the two low trim bits read zero
  AST_TRIM_LOW: assert property ((st_q.ack && idx == IDX_TRIM)
                                 |-> wb_dat_out[TRIM_LSB-1:0] == '0)
    else $error("trim low bits not zero");

  // ==========================================================
  // checks: program counter
  // ==========================================================
  // a step adds one, wrapping at the top of the space
  AST_PC_STEP: assert property ((pc_cmd_in.step && !pc_cmd_in.jump
                                 && !wr_pcl && !any_rst)
                                |=> pc_out == $past(pc_out) + PC_ONE)
    else $error("counter step wrong");
  // with no load the counter holds, upper bits included
  AST_PC_HOLD: assert property ((!any_rst && !wr_pcl
                                 && !pc_cmd_in.jump && !pc_cmd_in.step)
                                |=> $stable(pc_out))
    else $error("counter changed without load");
  // a low byte read returns the counter low byte
  AST_PCL_READ: assert property ((st_q.ack && idx == IDX_PC_LOW)
                                 |-> wb_dat_out[REG_W-1:0] == $past(pc_out[PCL_W-1:0]))
    else $error("low byte read wrong");
  // call or jump takes its low bits from the operand
  AST_OPER_LOW: assert property ((pc_cmd_in.jump && !any_rst && !wr_pcl)
                                 |=> pc_out[OPER_W-1:0] == $past(pc_cmd_in.oper))
    else $error("jump operand not loaded");
  // a latch write keeps its five implemented bits
  AST_LATCH_WR: assert property ((wr_go && idx == IDX_LATCH)
                                 |=> st_q.latch == $past(wdat[LATCH_W-1:0]))
    else $error("upper latch write lost");

  // ==========================================================
  // checks: register bus
  // ==========================================================
  // a fresh request is answered on the next cycle
  AST_ACK_NEXT: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
    else $error("request not answered");
  // no answer without a request
  AST_ACK_REQ: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("answer without request");

endmodule : cs_core

`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import cs_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  // ==========================================================
  logic             clk_sys_in;  // 100 MHz core clock
  logic             reset_n_in;  // synchronous, active low
  logic             wb_cyc_in;   // bus cycle
  logic             wb_stb_in;   // bus strobe
  logic             wb_we_in;    // bus write
  logic [9:0]       wb_adr_in;   // byte address
  logic [3:0]       wb_sel_in;   // byte lanes
  logic [31:0]      wb_dat_in;   // write data
  logic [31:0]      wb_dat_out;  // read data
  logic             wb_ack_out;  // bus answer
  cs_evt_t          evt_in;      // event pulses
  logic             cmp_level_in; // comparator level
  cs_pc_cmd_t       pc_cmd_in;   // counter control
  logic [PC_W-1:0]  pc_out;      // program counter
  logic [TRIM_W-1:0] trim_out;   // trim field
  logic             irq_out;     // interrupt level
  int               mismatches;  // failed compares
  int               checked;     // compares made
  logic [31:0]      rd;          // last read word

  cs_core #(.ADR_W(10)) cs_core_inst (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .evt_in(evt_in), .cmp_level_in(cmp_level_in),
    .pc_cmd_in(pc_cmd_in), .pc_out(pc_out), .trim_out(trim_out), .irq_out(irq_out)
  );

  // ==========================================================
  // clock and helpers
  // ==========================================================
  // free running clock, 10 ns period
  always #5 clk_sys_in = ~clk_sys_in;

  // compare with case inequality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic single cycle, waits for ack; only the watchdog ends a hang
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_sel_in <= 4'h1;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {24'h00_0000, wd};
    do begin
      @(posedge clk_sys_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask : wb

  // read a register and compare its byte
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask : rchk

  // one-cycle event pulse, then let the flag land
  task automatic pulse(input logic [5:0] e);
    @(posedge clk_sys_in);
    evt_in <= cs_evt_t'(e);
    @(posedge clk_sys_in);
    evt_in <= cs_evt_t'(6'h00);
    @(posedge clk_sys_in);
    #1;
  endtask : pulse

  // ==========================================================
  // scenarios
  // ==========================================================
  // values seen straight after reset
  task automatic t_reset();
    chk(pc_out, 13'h0000);
    rchk(IDX_RCAUSE, 8'h01);
    rchk(IDX_TRIM, 8'h80);
    rchk(IDX_FLAGS, 8'h00);
    rchk(8'h20, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // each event sets its sticky flag, software zero clears, irq follows mask
  task automatic t_flags();
    pulse(6'h20);
    rchk(IDX_FLAGS, 8'h80);
    pulse(6'h10);
    rchk(IDX_FLAGS, 8'hc0);
    pulse(6'h08);
    rchk(IDX_FLAGS, 8'hc1);
    @(posedge clk_sys_in);
    cmp_level_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    rchk(IDX_FLAGS, 8'hc9);
    wb(1'b1, IDX_FLAGS, 8'hff);
    rchk(IDX_FLAGS, 8'hc9);
    chk(irq_out, 1'b0);
    wb(1'b1, IDX_MASK, 8'h08);
    @(posedge clk_sys_in);
    #1;
    chk(irq_out, 1'b1);
    wb(1'b1, IDX_FLAGS, 8'h00);
    rchk(IDX_FLAGS, 8'h00);
    chk(irq_out, 1'b0);
    $display("test flags done");
  endtask : t_flags

  // reset cause bits, unimplemented upper bits, stickiness
  task automatic t_rcause();
    wb(1'b1, IDX_RCAUSE, 8'hff);
    rchk(IDX_RCAUSE, 8'h03);
    pulse(6'h02);
    rchk(IDX_RCAUSE, 8'h02);
    repeat (5) @(posedge clk_sys_in);
    rchk(IDX_RCAUSE, 8'h02);
    wb(1'b1, IDX_RCAUSE, 8'h03);
    pulse(6'h04);
    rchk(IDX_RCAUSE, 8'h01);
    $display("test reset cause done");
  endtask : t_rcause

  // trim field in the upper six bits
  task automatic t_trim();
    wb(1'b1, IDX_TRIM, 8'hff);
    rchk(IDX_TRIM, 8'hfc);
    chk(trim_out, 6'h3f);
    wb(1'b1, IDX_TRIM, 8'h00);
    rchk(IDX_TRIM, 8'h00);
    chk(trim_out, 6'h00);
    $display("test trim done");
  endtask : t_trim

  // program counter loads from low byte write, jump, step and reset
  task automatic t_pc();
    wb(1'b1, IDX_LATCH, 8'hff);
    rchk(IDX_LATCH, 8'h1f);
    wb(1'b1, IDX_PC_LOW, 8'h34);
    rchk(IDX_PC_LOW, 8'h34);
    chk(pc_out, 13'h1f34);
    wb(1'b1, IDX_LATCH, 8'h15);
    @(posedge clk_sys_in);
    pc_cmd_in <= '{step: 1'b0, jump: 1'b1, oper: 11'h5a5};
    @(posedge clk_sys_in);
    pc_cmd_in <= '{step: 1'b1, jump: 1'b0, oper: 11'h000};
    #1;
    chk(pc_out, 13'h15a5);
    @(posedge clk_sys_in);
    pc_cmd_in <= '{step: 1'b0, jump: 1'b0, oper: 11'h000};
    #1;
    chk(pc_out, 13'h15a6);
    pulse(6'h01);
    chk(pc_out, 13'h0000);
    $display("test program counter done");
  endtask : t_pc

  // ==========================================================
  // verdict, watchdog and main sequence
  // ==========================================================
  task automatic give_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // cut a hang short well beyond the expected run
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    mismatches++;
    give_verdict();
  end

  initial begin
    clk_sys_in   = 1'b0;
    reset_n_in   = 1'b0;
    wb_cyc_in    = 1'b0;
    wb_stb_in    = 1'b0;
    wb_we_in     = 1'b0;
    wb_adr_in    = 10'h000;
    wb_sel_in    = 4'h1;
    wb_dat_in    = 32'h0000_0000;
    evt_in       = cs_evt_t'(6'h00);
    cmp_level_in = 1'b0;
    pc_cmd_in    = '0;
    mismatches   = 0;
    checked      = 0;
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    t_reset();
    t_flags();
    t_rcause();
    t_trim();
    t_pc();
    give_verdict();
  end

endmodule : testbench

`default_nettype wire
